// ---- hw/adc_out_pkg.sv ----
package adc_out_pkg;

    localparam int SAMPLE_W = 14;
    localparam int CLK_HZ = 50_000_000;

    // Register offsets
    localparam logic [12:0] ADDR_CHAN_SELECT = 13'h0005;
    localparam logic [12:0] ADDR_POWER_MODE = 13'h0008;
    localparam logic [12:0] ADDR_STABILIZER = 13'h0009;
    localparam logic [12:0] ADDR_STATUS = 13'h000A;
    localparam logic [12:0] ADDR_DIVIDER = 13'h000B;
    localparam logic [12:0] ADDR_OUT_CHAN_DIS = 13'h0014;
    localparam logic [12:0] ADDR_DCO_POLARITY = 13'h0016;
    localparam logic [12:0] ADDR_DCO_DELAY = 13'h0017;
    localparam logic [12:0] ADDR_DIV_ALIGN = 13'h0100;

    // Field positions
    localparam int CODING_LSB = 0;
    localparam int CHAN_DIS_BIT = 4;
    localparam int INTERLEAVE_BIT = 5;
    localparam int DCO_INV_BIT = 7;
    localparam int DCO_DLY_BIT = 7;
    localparam int ALIGN_EN_BIT = 1;
    localparam int ALIGN_ONCE_BIT = 2;
    localparam int STAT_LOCKED_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 1;
    localparam int STAT_ARMED_BIT = 2;

    // Reset values
    localparam logic [1:0] CHAN_SELECT_RST = 2'h3;
    localparam logic [2:0] RATIO_M1_RST = 3'h0;
    localparam logic DCS_EN_RST = 1'b1;

    // Power states, Gray along run -> standby -> down
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_DOWN = 2'b11
    } pwr_t;

    typedef enum logic [1:0] {
        CODE_OFFSET = 2'b00,
        CODE_TWOS = 2'b01,
        CODE_GRAY = 2'b10
    } coding_t;

    // Stabilizer timing
    localparam int DCS_MIN_HZ = 20_000_000;
    localparam int DCS_RELOCK_MIN_NS = 1500;
    localparam int DCS_RELOCK_MAX_NS = 5000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    // Longest wait rounds up to whole cycles
    localparam int DCS_RELOCK_CYC =
        (DCS_RELOCK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : adc_out_pkg

// ---- hw/adc_clock_sync_output_logic.sv ----
`timescale 1ns/1ns
module adc_clock_sync_output_logic #(
    parameter int LATENCY = 12,
    parameter int RELOCK_CYC = adc_out_pkg::DCS_RELOCK_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic align_in_i,
    input wire logic power_down_pin_i,
    input wire logic output_disable_n_i,
    input wire logic serial_select_n_i,
    input wire logic format_select_strap_i,
    input wire logic stabilizer_select_strap_i,
    input wire logic [adc_out_pkg::SAMPLE_W-1:0] sample_a_i,
    input wire logic [adc_out_pkg::SAMPLE_W-1:0] sample_b_i,
    input wire logic over_a_i,
    input wire logic over_b_i,
    input wire logic reg_wr_i,
    input wire logic [12:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic conv_strobe_o,
    output logic stabilizer_active_o,
    output logic reference_on_o,
    output logic powered_down_o,
    output logic [adc_out_pkg::SAMPLE_W-1:0] data_a_o,
    output logic data_a_oe_o,
    output logic over_range_a_o,
    output logic [adc_out_pkg::SAMPLE_W-1:0] data_b_o,
    output logic data_b_oe_o,
    output logic over_range_b_o,
    output logic data_capture_clock_out_a_o,
    output logic data_capture_clock_out_a_oe_o,
    output logic data_capture_clock_out_b_o,
    output logic data_capture_clock_out_b_oe_o
);

    localparam int W = adc_out_pkg::SAMPLE_W;

    typedef logic [W:0] word_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic armed;
        logic [2:0] cnt;
        logic strobe;
        logic [1:0] chan_sel;
        logic [1:0] chan_dis;
        logic [1:0] dco_dly;
        adc_out_pkg::pwr_t pwr;
        logic dcs_en;
        logic [2:0] ratio_m1;
        logic [1:0] coding;
        logic interleave;
        logic dco_inv;
        logic align_en;
        logic align_once;
        logic [7:0] lock_cnt;
        logic locked;
        logic strap_done;
        logic strap_fmt;
        logic strap_dcs;
        word_t [LATENCY-1:0] pipe_a;
        word_t [LATENCY-1:0] pipe_b;
        logic b_pend;
        word_t out_a;
        word_t out_b;
        logic oe_a;
        logic oe_b;
        logic dco_raw;
        logic dco_a;
        logic dco_b;
        logic active;
        logic [7:0] rdata;
        logic pwr_dn;
        logic ref_on;
    } state_t;

    state_t s_q;
    state_t s_d;

    function automatic logic [W-1:0] encode(
        input logic [W-1:0] ob,
        input logic [1:0] mode
    );
        logic [W-1:0] r;
        r = ob;
        case (mode)
            adc_out_pkg::CODE_TWOS: r = {~ob[W-1], ob[W-2:0]};
            adc_out_pkg::CODE_GRAY: r = ob ^ (ob >> 1);
            default: r = ob;
        endcase
        return r;
    endfunction : encode

    function automatic logic addr_is(
        input logic [12:0] a,
        input logic [12:0] ref_a
    );
        return a == ref_a;
    endfunction : addr_is

    ////////////////////////////////////////////////////////////////////////
    // Combinational next state

    logic spi_mode, wr, pd, stby, running, align_evt, align_ok;
    logic eff_dcs, rate_ok, dco_lvl, chan_out_en;
    logic [1:0] eff_coding;
    logic [3:0] ratio;
    logic [2:0] half;
    logic [7:0] sel_dis, sel_dly, status;

    always_comb begin
        s_d = s_q;
        spi_mode = ~serial_select_n_i;
        wr = reg_wr_i & spi_mode;
        ratio = {1'b0, s_q.ratio_m1} + 4'h1;
        half = ratio[3:1];
        // Strap capture on the first edge after reset release
        if (!s_q.strap_done) begin
            s_d.strap_done = 1'b1;
            s_d.strap_fmt = format_select_strap_i;
            s_d.strap_dcs = stabilizer_select_strap_i;
        end
        // Only the second and third stages feed the edge detector
        s_d.sync1 = align_in_i;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        align_evt = s_q.sync2 & ~s_q.sync3;
        align_ok = align_evt & s_q.align_en
            & (~s_q.align_once | s_q.armed);
        // Register writes
        if (wr) begin
            if (addr_is(reg_addr_i, adc_out_pkg::ADDR_CHAN_SELECT)) begin
                s_d.chan_sel = reg_wdata_i[1:0];
            end
            if (addr_is(reg_addr_i, adc_out_pkg::ADDR_POWER_MODE)) begin
                case (reg_wdata_i[1:0])
                    2'b01: s_d.pwr = adc_out_pkg::PWR_DOWN;
                    2'b10: s_d.pwr = adc_out_pkg::PWR_STANDBY;
                    default: s_d.pwr = adc_out_pkg::PWR_RUN;
                endcase
            end
            if (addr_is(reg_addr_i, adc_out_pkg::ADDR_STABILIZER)) begin
                s_d.dcs_en = reg_wdata_i[0];
            end
            if (addr_is(reg_addr_i, adc_out_pkg::ADDR_DIVIDER)) begin
                s_d.ratio_m1 = reg_wdata_i[2:0];
            end
            if (addr_is(reg_addr_i, adc_out_pkg::ADDR_OUT_CHAN_DIS)) begin
                s_d.coding = reg_wdata_i[adc_out_pkg::CODING_LSB +: 2];
                s_d.interleave = reg_wdata_i[adc_out_pkg::INTERLEAVE_BIT];
                for (int c = 0; c < 2; c++) begin
                    if (s_q.chan_sel[c]) begin
                        s_d.chan_dis[c] =
                            reg_wdata_i[adc_out_pkg::CHAN_DIS_BIT];
                    end
                end
            end
            if (addr_is(reg_addr_i, adc_out_pkg::ADDR_DCO_POLARITY)) begin
                s_d.dco_inv = reg_wdata_i[adc_out_pkg::DCO_INV_BIT];
            end
            if (addr_is(reg_addr_i, adc_out_pkg::ADDR_DCO_DELAY)) begin
                for (int c = 0; c < 2; c++) begin
                    if (s_q.chan_sel[c]) begin
                        s_d.dco_dly[c] = reg_wdata_i[adc_out_pkg::DCO_DLY_BIT];
                    end
                end
            end
        end
        // A write re-arms one-shot alignment and wins over its use
        if (align_ok) begin
            s_d.armed = 1'b0;
        end
        if (wr && addr_is(reg_addr_i, adc_out_pkg::ADDR_DIV_ALIGN)) begin
            s_d.align_en = reg_wdata_i[adc_out_pkg::ALIGN_EN_BIT];
            s_d.align_once = reg_wdata_i[adc_out_pkg::ALIGN_ONCE_BIT];
            s_d.armed = 1'b1;
        end
        // Power state
        pd = power_down_pin_i | (s_q.pwr == adc_out_pkg::PWR_DOWN);
        stby = ~pd & (s_q.pwr == adc_out_pkg::PWR_STANDBY);
        running = ~pd & ~stby;
        s_d.pwr_dn = s_d.pwr == adc_out_pkg::PWR_DOWN;
        s_d.ref_on = s_d.pwr != adc_out_pkg::PWR_DOWN;
        // Divider: count 0 is the sampling edge
        s_d.strobe = 1'b0;
        if (!running) begin
            s_d.cnt = 3'h0;
        end else if (align_ok) begin
            s_d.cnt = 3'h0;
        end else begin
            s_d.cnt = (s_q.cnt >= s_q.ratio_m1) ? 3'h0 : s_q.cnt + 3'h1;
            s_d.strobe = (s_q.cnt >= s_q.ratio_m1);
        end
        // Stabilizer: strap or register, rate floor, relock wait
        eff_dcs = spi_mode ? s_q.dcs_en : s_q.strap_dcs;
        rate_ok = ({28'h0000_000, ratio} * adc_out_pkg::DCS_MIN_HZ)
            <= adc_out_pkg::CLK_HZ;
        // Frequency change restarts the wait; logic clock untouched
        if (s_d.ratio_m1 != s_q.ratio_m1 || (s_d.dcs_en && !s_q.dcs_en)) begin
            s_d.lock_cnt = 8'h00;
            s_d.locked = 1'b0;
        end else if (!s_q.locked) begin
            if (32'(s_q.lock_cnt) >= RELOCK_CYC - 1) begin
                s_d.locked = 1'b1;
            end else begin
                s_d.lock_cnt = s_q.lock_cnt + 8'h01;
            end
        end
        s_d.active = eff_dcs & rate_ok & s_q.locked & running;
        // Output coding
        eff_coding = spi_mode ? s_q.coding
            : (s_q.strap_fmt ? adc_out_pkg::CODE_TWOS
                             : adc_out_pkg::CODE_OFFSET);
        // Pipeline advances once per conversion
        if (s_d.strobe) begin
            s_d.pipe_a = {s_q.pipe_a[LATENCY-2:0],
                {over_a_i, sample_a_i}};
            s_d.pipe_b = {s_q.pipe_b[LATENCY-2:0],
                {over_b_i, sample_b_i}};
            s_d.out_a = {s_q.pipe_a[LATENCY-1][W],
                encode(s_q.pipe_a[LATENCY-1][W-1:0], eff_coding)};
            s_d.out_b = {s_q.pipe_b[LATENCY-1][W],
                encode(s_q.pipe_b[LATENCY-1][W-1:0], eff_coding)};
        end
        // Interleave: B follows A on the A bus one clock later, for ratios above 1
        s_d.b_pend = s_d.strobe & s_q.interleave & spi_mode;
        if (s_q.b_pend) begin
            s_d.out_a = s_q.out_b;
        end
        // Capture clock: low at data change, high mid-conversion, for ratios above 1
        dco_lvl = (s_d.cnt >= half);
        s_d.dco_raw = dco_lvl ^ s_q.dco_inv;
        // Extra delay shifts the edge one clock later
        s_d.dco_a = s_q.dco_dly[0] ? s_q.dco_raw : s_d.dco_raw;
        s_d.dco_b = s_q.dco_dly[1] ? s_q.dco_raw : s_d.dco_raw;
        // Drivers
        chan_out_en = running & ~output_disable_n_i;
        s_d.oe_a = chan_out_en & ~(spi_mode & s_q.chan_dis[0]);
        s_d.oe_b = chan_out_en & ~(spi_mode & s_q.chan_dis[1])
            & ~(spi_mode & s_q.interleave);
        // Read-back, registered; first selected channel wins
        sel_dis = {3'h0, s_q.chan_sel[0] ? s_q.chan_dis[0] : s_q.chan_dis[1],
            4'h0};
        sel_dis[adc_out_pkg::INTERLEAVE_BIT] = s_q.interleave;
        sel_dis[adc_out_pkg::CODING_LSB +: 2] = s_q.coding;
        sel_dly = 8'h00;
        sel_dly[adc_out_pkg::DCO_DLY_BIT] =
            s_q.chan_sel[0] ? s_q.dco_dly[0] : s_q.dco_dly[1];
        status = 8'h00;
        status[adc_out_pkg::STAT_LOCKED_BIT] = s_q.locked;
        status[adc_out_pkg::STAT_ACTIVE_BIT] = s_q.active;
        status[adc_out_pkg::STAT_ARMED_BIT] = s_q.armed;
        case (reg_addr_i)
            adc_out_pkg::ADDR_CHAN_SELECT: s_d.rdata = {6'h00, s_q.chan_sel};
            adc_out_pkg::ADDR_POWER_MODE: s_d.rdata = {6'h00,
                s_q.pwr == adc_out_pkg::PWR_DOWN,
                s_q.pwr == adc_out_pkg::PWR_STANDBY};
            adc_out_pkg::ADDR_STABILIZER: s_d.rdata = {7'h00, s_q.dcs_en};
            adc_out_pkg::ADDR_STATUS: s_d.rdata = status;
            adc_out_pkg::ADDR_DIVIDER: s_d.rdata = {5'h00, s_q.ratio_m1};
            adc_out_pkg::ADDR_OUT_CHAN_DIS: s_d.rdata = sel_dis;
            adc_out_pkg::ADDR_DCO_POLARITY:
                s_d.rdata = {s_q.dco_inv, 7'h00};
            adc_out_pkg::ADDR_DCO_DELAY: s_d.rdata = sel_dly;
            adc_out_pkg::ADDR_DIV_ALIGN: s_d.rdata = {5'h00,
                s_q.align_once, s_q.align_en, 1'b0};
            default: s_d.rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
            s_q.chan_sel <= adc_out_pkg::CHAN_SELECT_RST;
            s_q.pwr <= adc_out_pkg::PWR_RUN;
            s_q.dcs_en <= adc_out_pkg::DCS_EN_RST;
            s_q.ratio_m1 <= adc_out_pkg::RATIO_M1_RST;
            s_q.strap_dcs <= adc_out_pkg::DCS_EN_RST;
            s_q.ref_on <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata_o = s_q.rdata;
    assign conv_strobe_o = s_q.strobe;
    assign stabilizer_active_o = s_q.active;
    assign reference_on_o = s_q.ref_on;
    assign powered_down_o = s_q.pwr_dn;
    assign data_a_o = s_q.out_a[W-1:0];
    assign over_range_a_o = s_q.out_a[W];
    assign data_b_o = s_q.out_b[W-1:0];
    assign over_range_b_o = s_q.out_b[W];
    assign data_a_oe_o = s_q.oe_a;
    assign data_b_oe_o = s_q.oe_b;
    assign data_capture_clock_out_a_o = s_q.dco_a;
    assign data_capture_clock_out_b_o = s_q.dco_b;
    assign data_capture_clock_out_a_oe_o = s_q.oe_a;
    assign data_capture_clock_out_b_oe_o = s_q.oe_b;

endmodule : adc_clock_sync_output_logic

// ---- dv/capture_model.sv ----
`timescale 1ns/1ns
module capture_model (
    input wire logic dco_i,
    input wire logic oe_i,
    input wire logic [adc_out_pkg::SAMPLE_W-1:0] data_i,
    output logic [adc_out_pkg::SAMPLE_W-1:0] cap_o
);
    // A floated bus is never latched; cap_o keeps the last value taken while driven
    always @(posedge dco_i) begin
        if (oe_i) begin
            cap_o <= data_i;
        end
    end
endmodule : capture_model

// ---- dv/out_logic_sva.sv ----
`timescale 1ns/1ns
module out_logic_sva (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic power_down_pin_i,
    input wire logic output_disable_n_i,
    input wire logic conv_strobe_o,
    input wire logic reference_on_o,
    input wire logic powered_down_o,
    input wire logic [adc_out_pkg::SAMPLE_W-1:0] data_b_o,
    input wire logic over_range_b_o,
    input wire logic data_a_oe_o,
    input wire logic data_b_oe_o,
    input wire logic data_capture_clock_out_a_oe_o,
    input wire logic data_capture_clock_out_b_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    AST_PD_FLOAT: assert property (
        power_down_pin_i [*3] |-> !data_a_oe_o && !data_b_oe_o)
        else $error("outputs driven in pin power-down");
    AST_PD_HALT: assert property (
        power_down_pin_i [*3] |-> !conv_strobe_o)
        else $error("conversion during pin power-down");
    AST_OED_FLOAT: assert property (
        output_disable_n_i [*2] |-> !data_a_oe_o && !data_b_oe_o)
        else $error("outputs driven while disabled");
    AST_CLK_A_OE: assert property (
        data_capture_clock_out_a_oe_o == data_a_oe_o)
        else $error("capture clock A enable differs from data");
    AST_CLK_B_OE: assert property (
        data_capture_clock_out_b_oe_o == data_b_oe_o)
        else $error("capture clock B enable differs from data");
    AST_REF_ON: assert property (
        reference_on_o != powered_down_o)
        else $error("reference state wrong for power mode");
    AST_DATA_HOLD: assert property (
        !conv_strobe_o |-> $stable(data_b_o))
        else $error("data B changed without a conversion");
    AST_OVER_HOLD: assert property (
        !conv_strobe_o |-> $stable(over_range_b_o))
        else $error("overrange B changed without a conversion");
    COV_STROBE: cover property (conv_strobe_o ##1 !conv_strobe_o);
    COV_PIN_DOWN: cover property (power_down_pin_i [*3]);
    COV_REG_DOWN: cover property (powered_down_o);
endmodule : out_logic_sva

bind adc_clock_sync_output_logic out_logic_sva u_sva (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .power_down_pin_i(power_down_pin_i),
    .output_disable_n_i(output_disable_n_i),
    .conv_strobe_o(conv_strobe_o),
    .reference_on_o(reference_on_o),
    .powered_down_o(powered_down_o),
    .data_b_o(data_b_o),
    .over_range_b_o(over_range_b_o),
    .data_a_oe_o(data_a_oe_o),
    .data_b_oe_o(data_b_oe_o),
    .data_capture_clock_out_a_oe_o(data_capture_clock_out_a_oe_o),
    .data_capture_clock_out_b_oe_o(data_capture_clock_out_b_oe_o)
);

// ---- dv/tb.sv ----
`timescale 1ns/1ns
module tb;
    logic clk_i, nrst_i, align_in_i, power_down_pin_i, output_disable_n_i;
    logic serial_select_n_i, format_select_strap_i, stabilizer_select_strap_i;
    logic reg_wr_i, over_a_i, over_b_i, conv_strobe_o, stabilizer_active_o;
    logic reference_on_o, powered_down_o, data_a_oe_o, data_b_oe_o;
    logic over_range_a_o, over_range_b_o, dco_a, dco_a_oe, dco_b, dco_b_oe;
    logic [12:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o;
    logic [13:0] sample_a_i, sample_b_i, data_a_o, data_b_o, cap_a;
    int err_count, checks_done;

    adc_clock_sync_output_logic #(.LATENCY(12), .RELOCK_CYC(8)) u_dut (
        .clk_i, .nrst_i, .align_in_i, .power_down_pin_i, .output_disable_n_i,
        .serial_select_n_i, .format_select_strap_i, .stabilizer_select_strap_i,
        .sample_a_i, .sample_b_i, .over_a_i, .over_b_i, .reg_wr_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .conv_strobe_o, .stabilizer_active_o,
        .reference_on_o, .powered_down_o, .data_a_o, .data_a_oe_o,
        .over_range_a_o, .data_b_o, .data_b_oe_o, .over_range_b_o,
        .data_capture_clock_out_a_o(dco_a),
        .data_capture_clock_out_a_oe_o(dco_a_oe),
        .data_capture_clock_out_b_o(dco_b),
        .data_capture_clock_out_b_oe_o(dco_b_oe));
    capture_model u_cap (.dco_i(dco_a), .oe_i(dco_a_oe), .data_i(data_a_o),
        .cap_o(cap_a));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Expected output code, built from the coding rules
    function automatic logic [13:0] code_of(input logic [13:0] v,
        input int m);
        return m == 1 ? v ^ 14'h2000 : m == 2 ? v ^ (v >> 1) : v;
    endfunction : code_of
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(reg_rdata_o, e);
    endtask : rd_chk
    // Outputs read at the falling edge, clear of the launch edge
    task automatic to_strobe(output int n);
        for (n = 1; n < 40; n++) begin
            @(negedge clk_i);
            if (conv_strobe_o === 1'b1) break;
        end
    endtask : to_strobe
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wait_n
    ////////////////////////////////////////////////////////////////////////
    task automatic t_ratio;
        int n, r;
        for (int i = 1; i <= 8; i++) begin
            r = i % 8 + 1;
            wr(adc_out_pkg::ADDR_DIVIDER, 8'(r - 1));
            to_strobe(n);
            to_strobe(n);
            chk(16'(n), 16'(r));
            chk(stabilizer_active_o, 1'b0);
            wait_n(12);
            chk(stabilizer_active_o, r <= 2);
        end
    endtask : t_ratio
    task automatic pulse(input int ph, output int d);
        to_strobe(d);
        repeat (ph) @(posedge clk_i);
        align_in_i <= 1'b1;
        @(posedge clk_i);
        align_in_i <= 1'b0;
        to_strobe(d);
    endtask : pulse
    task automatic t_align;
        int d1, d2, d3, d4;
        wr(adc_out_pkg::ADDR_DIVIDER, 8'h07);
        wr(adc_out_pkg::ADDR_DIV_ALIGN, 8'h02);
        pulse(2, d1);
        pulse(5, d2);
        chk(16'(d2), 16'(d1));
        chk(d1 > 8, 1'b1);
        wr(adc_out_pkg::ADDR_DIV_ALIGN, 8'h06);
        rd_chk(adc_out_pkg::ADDR_DIV_ALIGN, 8'h06);
        pulse(2, d3);
        pulse(5, d4);
        chk(16'(d3), 16'(d1));
        chk(d4 < d1, 1'b1);
    endtask : t_align
    task automatic t_coding;
        logic [13:0] v, e;
        logic [13:0] vals [4] = '{14'h0000, 14'h2000, 14'h3fff, 14'h1a5c};
        wr(adc_out_pkg::ADDR_DIVIDER, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(adc_out_pkg::ADDR_OUT_CHAN_DIS, 8'(m));
            for (int k = 0; k < 4; k++) begin
                v = vals[k];
                e = code_of(v, m);
                @(posedge clk_i);
                sample_a_i <= v;
                sample_b_i <= ~v;
                over_a_i <= k[0];
                over_b_i <= k[1];
                wait_n(16);
                chk(data_a_o, e);
                chk(over_range_a_o, k[0]);
                chk(data_b_o, code_of(~v, m));
                chk(over_range_b_o, k[1]);
            end
        end
    endtask : t_coding
    task automatic t_latency;
        int n;
        @(posedge clk_i);
        sample_a_i <= 14'h0155;
        wait_n(20);
        @(posedge clk_i);
        sample_a_i <= 14'h2aa6;
        for (n = 1; n < 40; n++) begin
            @(negedge clk_i);
            if (data_a_o !== 14'h0155) break;
        end
        // Counted from the negedge before the taking edge, then twelve stages and the output register
        chk(16'(n), 16'(14));
        chk(data_a_o, 14'h2aa6);
    endtask : t_latency
    task automatic t_capture;
        int n;
        wr(adc_out_pkg::ADDR_DIVIDER, 8'h01);
        @(posedge clk_i);
        sample_a_i <= 14'h1234;
        sample_b_i <= 14'h0abc;
        wait_n(30);
        chk(cap_a, 14'h1234);
        wr(adc_out_pkg::ADDR_DCO_DELAY, 8'h80);
        wait_n(30);
        chk(cap_a, 14'h1234);
        wr(adc_out_pkg::ADDR_DCO_DELAY, 8'h00);
        wr(adc_out_pkg::ADDR_OUT_CHAN_DIS, 8'h20);
        wait_n(30);
        to_strobe(n);
        chk(data_a_o, 14'h1234);
        @(negedge clk_i);
        chk(data_a_o, 14'h0abc);
        chk({data_a_oe_o, data_b_oe_o}, 2'b10);
        wr(adc_out_pkg::ADDR_OUT_CHAN_DIS, 8'h00);
    endtask : t_capture
    task automatic t_disable;
        int n;
        @(posedge clk_i);
        output_disable_n_i <= 1'b1;
        wait_n(3);
        chk({data_a_oe_o, data_b_oe_o, dco_a_oe, dco_b_oe}, 4'h0);
        @(posedge clk_i);
        output_disable_n_i <= 1'b0;
        wr(adc_out_pkg::ADDR_CHAN_SELECT, 8'h01);
        wr(adc_out_pkg::ADDR_OUT_CHAN_DIS, 8'h10);
        wait_n(3);
        chk({data_a_oe_o, data_b_oe_o, dco_a_oe, dco_b_oe}, 4'h5);
        wr(adc_out_pkg::ADDR_CHAN_SELECT, 8'h03);
        wr(adc_out_pkg::ADDR_OUT_CHAN_DIS, 8'h00);
        @(posedge clk_i);
        power_down_pin_i <= 1'b1;
        wait_n(3);
        n = 0;
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_i);
            n += int'(conv_strobe_o);
        end
        chk({data_a_oe_o, data_b_oe_o, powered_down_o, 13'(n)}, 16'h0);
        @(posedge clk_i);
        power_down_pin_i <= 1'b0;
        wr(adc_out_pkg::ADDR_POWER_MODE, 8'h01);
        wait_n(3);
        chk({powered_down_o, reference_on_o, data_a_oe_o}, 3'b100);
        wr(adc_out_pkg::ADDR_POWER_MODE, 8'h02);
        wait_n(3);
        chk({powered_down_o, reference_on_o, data_a_oe_o}, 3'b010);
        rd_chk(adc_out_pkg::ADDR_POWER_MODE, 8'h01);
        wr(adc_out_pkg::ADDR_POWER_MODE, 8'h00);
        rd_chk(13'h0003, 8'h00);
    endtask : t_disable
    // Straps are caught only after reset, so this runs last
    task automatic t_strap;
        @(posedge clk_i);
        nrst_i <= 1'b0;
        serial_select_n_i <= 1'b1;
        format_select_strap_i <= 1'b1;
        stabilizer_select_strap_i <= 1'b0;
        sample_a_i <= 14'h1234;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        wr(adc_out_pkg::ADDR_OUT_CHAN_DIS, 8'h02);
        wait_n(30);
        chk(data_a_o, 14'h3234);
        chk(stabilizer_active_o, 1'b0);
    endtask : t_strap
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst_i, align_in_i, power_down_pin_i, output_disable_n_i} = 4'h0;
        {serial_select_n_i, format_select_strap_i, reg_wr_i} = 3'h0;
        {over_a_i, over_b_i, stabilizer_select_strap_i} = 3'h1;
        {sample_a_i, sample_b_i, reg_addr_i, reg_wdata_i} = '0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd_chk(adc_out_pkg::ADDR_CHAN_SELECT, 8'h03);
        t_ratio;
        t_align;
        t_coding;
        t_latency;
        t_capture;
        t_disable;
        t_strap;
        end_of_test;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        end_of_test;
    end
endmodule : tb
